// *** design/rq_sideband_pkg.sv ***
// Purpose: constants and carriers for the requester stream sideband block
// Assumes: 512-bit streams, one clock, register port with 8-bit byte address
// Notes: register byte address is four times the register index
package rq_sideband_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL_IDX = 8'h00;
  localparam logic [7:0] REG_STATUS_IDX = 8'h01;
  localparam logic [7:0] REG_MASK_IDX = 8'h02;
  localparam logic [7:0] REG_STATE_IDX = 8'h03;
  localparam logic [7:0] REG_TABLE_IDX = 8'h10;
  localparam int TABLE_DEPTH = 16;
  localparam int TABLE_IDX_W = 4;
  localparam int CTRL_PARITY_BIT = 0;
  localparam int CTRL_STRADDLE_BIT = 1;
  localparam int EVT_PARITY_BIT = 0;
  localparam int EVT_SEQ_BIT = 1;
  localparam int EVT_CPL_BIT = 2;
  localparam int EVT_W = 3;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Stream geometry and timing
  // ----------------------------------------------------------------
  localparam int DATA_W = 512;
  localparam int BYTES = 64;
  localparam int DWORDS = 16;
  localparam int SEQ_LAG = 4;
  localparam logic [15:0] KEEP_ALL = 16'hFFFF;

  typedef struct packed {
    logic [1:0] present;
    logic [3:0] hint_type;
    logic [1:0] lookup_sel;
    logic [15:0] tag;
    logic [5:0] seq_first;
    logic [5:0] seq_second;
    logic [63:0] parity;
  } rq_fields_s;

  typedef struct packed {
    logic present;
    logic [1:0] hint_type;
    logic [7:0] tag;
  } hint_s;

  typedef struct packed {
    logic vld_a;
    logic [5:0] seq_a;
    logic vld_b;
    logic [5:0] seq_b;
  } seq_slot_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic first_beat;
    logic last;
    logic [4:0] desc_dw;
    logic [3:0] end_dw;
    logic [2:0] start_count;
    logic [7:0] start_ptrs;
  } cpl_src_s;

  typedef struct packed {
    logic [63:0] parity;
    logic discontinue;
    logic [15:0] eop_ptrs;
    logic [3:0] is_eop;
    logic [7:0] start_ptrs;
    logic [3:0] packet_start_flags;
    logic [63:0] byte_en;
  } cpl_side_s;

endpackage

// *** design/requester_stream_sideband.sv ***
// Purpose: request sideband capture and completion stream framing
// Assumes: all inputs synchronous to clock; one completion TLP source
// Notes: completion path takes at most one beat per two cycles, even when not stalled
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module requester_stream_sideband (
  input wire logic clock, // 40 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_write, // Write strobe
  input wire logic reg_read, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  output logic irq, // Level interrupt
  input wire logic request_stream_valid, // Request beat valid
  output logic request_stream_ready, // Request beat accepted
  input wire logic [511:0] request_stream_payload, // Request data
  input wire logic [1:0] request_stream_starts, // TLP starts in beat
  input wire logic request_stream_end, // Final beat of packet
  input wire rq_sideband_pkg::rq_fields_s request_sideband, // Per-packet fields
  output rq_sideband_pkg::hint_s hint_first, // Resolved hint, first TLP
  output rq_sideband_pkg::hint_s hint_second, // Resolved hint, second TLP
  output logic hint_strobe, // Pulse: hints updated
  output logic request_nullify, // Pulse: TLP nullified
  output logic internal_error, // Pulse: uncorrectable error
  output logic [5:0] progress_sequence_out_a, // Echoed first sequence
  output logic progress_valid_a, // Pulse: out_a valid
  output logic [5:0] progress_sequence_out_b, // Echoed second sequence
  output logic progress_valid_b, // Pulse: out_b valid
  input wire logic cpl_src_valid, // Internal completion beat valid
  output logic cpl_src_ready, // Internal completion beat taken
  input wire rq_sideband_pkg::cpl_src_s cpl_src, // Internal completion beat
  output logic [511:0] completion_stream_payload, // Completion data
  output rq_sideband_pkg::cpl_side_s completion_stream_sideband, // 161 bits
  output logic completion_last_flag, // Final beat marker
  output logic [15:0] completion_dword_keep, // Dword keep
  output logic completion_stream_valid, // Completion beat valid
  input wire logic completion_stream_ready // Completion beat accepted
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] ctrl;
    logic [rq_sideband_pkg::EVT_W-1:0] status;
    logic [rq_sideband_pkg::EVT_W-1:0] mask;
    logic [31:0] rdata;
    logic irq;
    logic rq_ready;
    logic in_packet;
    logic bad_parity;
    rq_sideband_pkg::hint_s hint_a;
    rq_sideband_pkg::hint_s hint_b;
    logic hint_stb;
    logic nullify;
    logic int_err;
    rq_sideband_pkg::seq_slot_s [rq_sideband_pkg::SEQ_LAG-1:0] seq_pipe;
    logic [511:0] c_data;
    rq_sideband_pkg::cpl_side_s c_side;
    logic c_last;
    logic [15:0] c_keep;
    logic c_valid;
    logic src_ready;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic [7:0] steer_table [rq_sideband_pkg::TABLE_DEPTH];
  logic table_we;
  logic [rq_sideband_pkg::TABLE_IDX_W-1:0] table_wa;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [63:0] odd_parity(input logic [511:0] d);
    logic [63:0] p;
    p = '0;
    for (int i = 0; i < rq_sideband_pkg::BYTES; i++) begin
      p[i] = ~(^d[i*8 +: 8]);
    end
    return p;
  endfunction

  // Dwords lo..hi inclusive, empty when lo exceeds hi
  function automatic logic [15:0] dword_span(input logic [4:0] lo, input logic [4:0] hi);
    logic [15:0] m;
    m = '0;
    for (int i = 0; i < rq_sideband_pkg::DWORDS; i++) begin
      m[i] = (5'(i) >= lo) && (5'(i) <= hi);
    end
    return m;
  endfunction

  function automatic logic [63:0] dw_to_bytes(input logic [15:0] m);
    logic [63:0] b;
    b = '0;
    for (int i = 0; i < rq_sideband_pkg::DWORDS; i++) begin
      b[i*4 +: 4] = {4{m[i]}};
    end
    return b;
  endfunction

  function automatic logic [3:0] start_code(input logic [2:0] n);
    logic [3:0] c;
    unique case (n)
      3'h0: c = 4'h0;
      3'h1: c = 4'h1;
      3'h2: c = 4'h3;
      3'h3: c = 4'h7;
      default: c = 4'hF;
    endcase
    return c;
  endfunction

  function automatic rq_sideband_pkg::hint_s resolve(input logic present,
      input logic [1:0] htype, input logic sel, input logic [7:0] tag,
      input logic [7:0] entry);
    rq_sideband_pkg::hint_s h;
    h.present = present;
    h.hint_type = present ? htype : 2'h0;
    h.tag = !present ? 8'h00 : (sel ? entry : tag);
    return h;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic rq_take;
  logic first_beat;
  logic beat_bad;
  logic src_take;
  logic out_take;
  logic straddle;
  logic [rq_sideband_pkg::EVT_W-1:0] events;
  logic [4:0] hi_dw;
  logic [15:0] pay_mask;
  logic [7:0] entry_a;
  logic [7:0] entry_b;

  assign entry_a = steer_table[request_sideband.tag[rq_sideband_pkg::TABLE_IDX_W-1:0]];
  assign entry_b = steer_table[request_sideband.tag[8 +: rq_sideband_pkg::TABLE_IDX_W]];
  assign table_we = reg_write && (reg_addr[7:2] >= rq_sideband_pkg::REG_TABLE_IDX[5:0]);
  assign table_wa = reg_addr[2 +: rq_sideband_pkg::TABLE_IDX_W];

  always_comb begin
    state_next = state_reg;
    straddle = state_reg.ctrl[rq_sideband_pkg::CTRL_STRADDLE_BIT];
    events = '0;
    state_next.hint_stb = 1'b0;
    state_next.nullify = 1'b0;
    state_next.int_err = 1'b0;
    state_next.rq_ready = 1'b1;

    // Request side: hint and sequence fields count only on the first accepted beat
    rq_take = request_stream_valid && state_reg.rq_ready;
    first_beat = rq_take && !state_reg.in_packet;
    if (first_beat) begin
      state_next.hint_a = resolve(request_sideband.present[0],
        request_sideband.hint_type[1:0], request_sideband.lookup_sel[0],
        request_sideband.tag[7:0], entry_a);
      state_next.hint_b = resolve(request_sideband.present[1] && request_stream_starts[1],
        request_sideband.hint_type[3:2], request_sideband.lookup_sel[1],
        request_sideband.tag[15:8], entry_b);
      state_next.hint_stb = 1'b1;
    end
    if (rq_take) begin
      state_next.in_packet = !request_stream_end;
    end

    // Parity error is sticky until the packet ends
    beat_bad = rq_take && state_reg.ctrl[rq_sideband_pkg::CTRL_PARITY_BIT]
      && (odd_parity(request_stream_payload) != request_sideband.parity);
    if (rq_take) begin
      state_next.bad_parity = !request_stream_end && (state_reg.bad_parity || beat_bad);
      if (request_stream_end && (state_reg.bad_parity || beat_bad)) begin
        state_next.nullify = 1'b1;
        state_next.int_err = 1'b1;
        events[rq_sideband_pkg::EVT_PARITY_BIT] = 1'b1;
      end
    end

    // Sequence echo after the fixed commit lag
    for (int i = rq_sideband_pkg::SEQ_LAG - 1; i > 0; i--) begin
      state_next.seq_pipe[i] = state_reg.seq_pipe[i-1];
    end
    state_next.seq_pipe[0].vld_a = first_beat;
    state_next.seq_pipe[0].seq_a = request_sideband.seq_first;
    state_next.seq_pipe[0].vld_b = first_beat && request_stream_starts[1];
    state_next.seq_pipe[0].seq_b = request_sideband.seq_second;
    if (state_reg.seq_pipe[rq_sideband_pkg::SEQ_LAG-1].vld_a) begin
      events[rq_sideband_pkg::EVT_SEQ_BIT] = 1'b1;
    end

    // Completion side: single output slot held while stalled
    out_take = state_reg.c_valid && completion_stream_ready;
    src_take = cpl_src_valid && state_reg.src_ready;
    if (out_take) begin
      state_next.c_valid = 1'b0;
      if (state_reg.c_last || state_reg.c_side.is_eop[0]) begin
        events[rq_sideband_pkg::EVT_CPL_BIT] = 1'b1;
      end
    end
    hi_dw = cpl_src.last ? {1'b0, cpl_src.end_dw} : 5'h0F;
    pay_mask = dword_span(cpl_src.desc_dw, hi_dw);
    if (src_take) begin
      state_next.c_valid = 1'b1;
      state_next.c_data = cpl_src.data;
      state_next.c_side.parity = odd_parity(cpl_src.data);
      state_next.c_side.discontinue = 1'b0;
      state_next.c_side.byte_en = dw_to_bytes(pay_mask);
      state_next.c_side.eop_ptrs = '0;
      state_next.c_side.is_eop = '0;
      if (straddle) begin
        state_next.c_last = 1'b0;
        state_next.c_keep = rq_sideband_pkg::KEEP_ALL;
        state_next.c_side.packet_start_flags = start_code(cpl_src.start_count);
        state_next.c_side.start_ptrs = cpl_src.start_ptrs;
        state_next.c_side.is_eop = {3'h0, cpl_src.last};
        state_next.c_side.eop_ptrs = {12'h000, cpl_src.end_dw};
      end else begin
        state_next.c_last = cpl_src.last;
        state_next.c_keep = cpl_src.last
          ? dword_span(5'h00, {1'b0, cpl_src.end_dw})
          : rq_sideband_pkg::KEEP_ALL;
        state_next.c_side.packet_start_flags = {3'h0, cpl_src.first_beat};
        state_next.c_side.start_ptrs = 8'h00;
      end
    end
    // Registered ready: only take a beat when the slot is sure to be free
    state_next.src_ready = !state_next.c_valid && !(state_reg.src_ready && cpl_src_valid);

    // Register port
    state_next.rdata = 32'h0000_0000;
    if (reg_write) begin
      unique case (reg_addr[7:2])
        rq_sideband_pkg::REG_CTRL_IDX[5:0]: state_next.ctrl = reg_wdata[1:0];
        rq_sideband_pkg::REG_MASK_IDX[5:0]:
          state_next.mask = reg_wdata[rq_sideband_pkg::EVT_W-1:0];
        default: ;
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr[7:2])
        rq_sideband_pkg::REG_CTRL_IDX[5:0]: state_next.rdata = {30'h0, state_reg.ctrl};
        rq_sideband_pkg::REG_STATUS_IDX[5:0]: state_next.rdata = {29'h0, state_reg.status};
        rq_sideband_pkg::REG_MASK_IDX[5:0]: state_next.rdata = {29'h0, state_reg.mask};
        rq_sideband_pkg::REG_STATE_IDX[5:0]:
          state_next.rdata = {28'h0, state_reg.c_valid, state_reg.src_ready,
            state_reg.bad_parity, state_reg.in_packet};
        default: begin
          if (reg_addr[7:2] >= rq_sideband_pkg::REG_TABLE_IDX[5:0]) begin
            state_next.rdata = {24'h0, steer_table[table_wa]};
          end
        end
      endcase
    end
    // Read clears, but a same-cycle event still lands
    if (reg_read && reg_addr[7:2] == rq_sideband_pkg::REG_STATUS_IDX[5:0]) begin
      state_next.status = events;
    end else begin
      state_next.status = state_reg.status | events;
    end
    state_next.irq = |(state_next.status & state_next.mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.ctrl <= rq_sideband_pkg::CTRL_RESET;
      state_reg.mask <= rq_sideband_pkg::MASK_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Table is not reset; software loads it before use
  always_ff @(posedge clock) begin
    if (table_we) begin
      steer_table[table_wa] <= reg_wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = state_reg.rdata;
  assign irq = state_reg.irq;
  assign request_stream_ready = state_reg.rq_ready;
  assign hint_first = state_reg.hint_a;
  assign hint_second = state_reg.hint_b;
  assign hint_strobe = state_reg.hint_stb;
  assign request_nullify = state_reg.nullify;
  assign internal_error = state_reg.int_err;
  assign progress_valid_a = state_reg.seq_pipe[rq_sideband_pkg::SEQ_LAG-1].vld_a;
  assign progress_sequence_out_a = state_reg.seq_pipe[rq_sideband_pkg::SEQ_LAG-1].seq_a;
  assign progress_valid_b = state_reg.seq_pipe[rq_sideband_pkg::SEQ_LAG-1].vld_b;
  assign progress_sequence_out_b = state_reg.seq_pipe[rq_sideband_pkg::SEQ_LAG-1].seq_b;
  assign cpl_src_ready = state_reg.src_ready;
  assign completion_stream_payload = state_reg.c_data;
  assign completion_stream_sideband = state_reg.c_side;
  assign completion_last_flag = state_reg.c_last;
  assign completion_dword_keep = state_reg.c_keep;
  assign completion_stream_valid = state_reg.c_valid;

endmodule

// *** testbench/requester_stream_sideband_props.sv ***
// Purpose: port-level checks for the requester stream sideband block
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind, sees only the top-level ports
`timescale 1ns/1ps
module requester_stream_sideband_props (
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic request_stream_valid, // Request valid
  input wire logic request_stream_end, // Request end beat
  input wire rq_sideband_pkg::rq_fields_s request_sideband, // Request fields
  input wire rq_sideband_pkg::hint_s hint_first, // First hint
  input wire logic hint_strobe, // Hint update
  input wire logic request_nullify, // Nullify pulse
  input wire logic internal_error, // Error pulse
  input wire logic [5:0] progress_sequence_out_a, // Echo a
  input wire logic progress_valid_a, // Echo a valid
  input wire logic cpl_src_valid, // Source valid
  input wire logic cpl_src_ready, // Source ready
  input wire rq_sideband_pkg::cpl_src_s cpl_src, // Source beat
  input wire logic [511:0] completion_stream_payload, // Completion data
  input wire rq_sideband_pkg::cpl_side_s completion_stream_sideband, // Sideband
  input wire logic completion_last_flag, // Last flag
  input wire logic [15:0] completion_dword_keep, // Keep
  input wire logic completion_stream_valid, // Completion valid
  input wire logic completion_stream_ready // Completion ready
);
  logic [63:0] par_ok;
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      par_ok[i] = ^{completion_stream_payload[8*i +: 8], completion_stream_sideband.parity[i]};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------
  a_stall_hold: assert property (
    completion_stream_valid && !completion_stream_ready |=> completion_stream_valid
    && $stable(completion_stream_payload) && $stable(completion_stream_sideband))
    else $error("completion beat changed while stalled");
  a_stall_refuse: assert property (
    completion_stream_valid && !completion_stream_ready |-> !cpl_src_ready)
    else $error("source taken while output slot full");
  a_keep_partial: assert property (
    completion_stream_valid && !completion_last_flag
    |-> completion_dword_keep == rq_sideband_pkg::KEEP_ALL)
    else $error("partial keep outside a final beat");
  a_last_no_eop: assert property (
    completion_last_flag |-> completion_stream_sideband.is_eop == 4'h0)
    else $error("last flag seen in straddle framing");
  a_src_data: assert property (
    cpl_src_valid && cpl_src_ready |=> completion_stream_valid
    && completion_stream_payload == $past(cpl_src.data))
    else $error("completion data not forwarded next cycle");
  a_odd_parity: assert property (
    completion_stream_valid |-> &par_ok)
    else $error("completion byte parity not odd");
  a_seq_echo: assert property (
    hint_strobe |-> ##3 progress_valid_a
    && progress_sequence_out_a == $past(request_sideband.seq_first, 4))
    else $error("sequence not echoed on time");
  a_nullify_err: assert property (
    request_nullify |-> internal_error && $past(request_stream_valid && request_stream_end))
    else $error("nullify without error or end beat");
  a_hint_present: assert property (
    hint_strobe |-> hint_first.present == $past(request_sideband.present[0]))
    else $error("hint presence not captured");
  a_hint_direct: assert property (
    hint_strobe && hint_first.present && !$past(request_sideband.lookup_sel[0])
    |-> hint_first.tag == $past(request_sideband.tag[7:0])
    && hint_first.hint_type == $past(request_sideband.hint_type[1:0]))
    else $error("direct hint fields wrong");
  c_stall: cover property (completion_stream_valid && !completion_stream_ready);
  c_nullify: cover property (request_nullify);
  c_partial: cover property (completion_stream_valid && completion_dword_keep != 16'hFFFF);
endmodule
bind requester_stream_sideband requester_stream_sideband_props props (.clock, .rst,
  .request_stream_valid, .request_stream_end, .request_sideband, .hint_first, .hint_strobe,
  .request_nullify, .internal_error, .progress_sequence_out_a, .progress_valid_a,
  .cpl_src_valid, .cpl_src_ready, .cpl_src, .completion_stream_payload,
  .completion_stream_sideband, .completion_last_flag, .completion_dword_keep,
  .completion_stream_valid, .completion_stream_ready);

// *** testbench/completion_sink.sv ***
// Purpose: user-side consumer of the completion stream
// Assumes: one clock, synchronous reset
// Notes: when stalling, ready is high one cycle in four
`timescale 1ns/1ps
module completion_sink (
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic stall, // Throttle ready
  input wire logic completion_stream_valid, // Beat valid
  input wire logic [511:0] completion_stream_payload, // Beat data
  input wire rq_sideband_pkg::cpl_side_s completion_stream_sideband, // Beat sideband
  input wire logic completion_last_flag, // Final beat
  input wire logic [15:0] completion_dword_keep, // Dword keep
  output logic completion_stream_ready, // Pacing
  output logic [31:0] beats, // Beats taken
  output logic [511:0] got_data, // Last beat data
  output rq_sideband_pkg::cpl_side_s got_side, // Last beat sideband
  output logic got_last, // Last beat flag
  output logic [15:0] got_keep // Last beat keep
);
  logic [1:0] phase;
  always_ff @(posedge clock) begin
    if (rst) begin
      phase <= 2'h0;
      beats <= 32'h0;
      completion_stream_ready <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      completion_stream_ready <= !stall || phase == 2'h3;
      if (completion_stream_valid && completion_stream_ready) begin
        beats <= beats + 32'h1;
        got_data <= completion_stream_payload;
        got_side <= completion_stream_sideband;
        got_last <= completion_last_flag;
        got_keep <= completion_dword_keep;
      end
    end
  end
endmodule

// *** testbench/requester_stream_sideband_tb.sv ***
// Purpose: self-checking bench for the requester stream sideband block
// Assumes: 40 MHz clock, register byte address is four times the index
// Notes: completion consumer stalls during framing tests
`timescale 1ns/1ps
module requester_stream_sideband_tb;
  logic clock, rst, reg_write, reg_read, irq, request_stream_valid, request_stream_ready;
  logic request_stream_end, hint_strobe, request_nullify, internal_error, progress_valid_a;
  logic progress_valid_b, cpl_src_valid, cpl_src_ready, completion_last_flag, stall, got_last;
  logic completion_stream_valid, completion_stream_ready;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, beats;
  logic [511:0] request_stream_payload, completion_stream_payload, got_data;
  logic [1:0] request_stream_starts;
  logic [5:0] progress_sequence_out_a, progress_sequence_out_b;
  logic [15:0] completion_dword_keep, got_keep;
  rq_sideband_pkg::rq_fields_s request_sideband;
  rq_sideband_pkg::hint_s hint_first, hint_second;
  rq_sideband_pkg::cpl_src_s cpl_src;
  rq_sideband_pkg::cpl_side_s completion_stream_sideband, got_side;
  int checks, num_errors;

  requester_stream_sideband dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .irq, .request_stream_valid, .request_stream_ready, .request_stream_payload,
    .request_stream_starts, .request_stream_end, .request_sideband, .hint_first, .hint_second,
    .hint_strobe, .request_nullify, .internal_error, .progress_sequence_out_a,
    .progress_valid_a, .progress_sequence_out_b, .progress_valid_b, .cpl_src_valid,
    .cpl_src_ready, .cpl_src, .completion_stream_payload, .completion_stream_sideband,
    .completion_last_flag, .completion_dword_keep, .completion_stream_valid,
    .completion_stream_ready);
  completion_sink sink (.clock, .rst, .stall, .completion_stream_valid,
    .completion_stream_payload, .completion_stream_sideband, .completion_last_flag,
    .completion_dword_keep, .completion_stream_ready, .beats, .got_data, .got_side,
    .got_last, .got_keep);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [511:0] seen, input logic [511:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [63:0] odd_par(input logic [511:0] d);
    for (int i = 0; i < 64; i++) odd_par[i] = ~^d[8*i +: 8];
  endfunction
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic send_rq(input logic e, input logic [1:0] s, input rq_sideband_pkg::rq_fields_s f,
      input logic [511:0] p);
    @(posedge clock);
    request_stream_valid <= 1'b1;
    request_stream_end <= e;
    request_stream_starts <= s;
    request_sideband <= f;
    request_stream_payload <= p;
    @(posedge clock);
    while (request_stream_ready !== 1'b1) @(posedge clock);
    request_stream_valid <= 1'b0;
  endtask
  task automatic send_cpl(input rq_sideband_pkg::cpl_src_s b);
    logic [31:0] n;
    n = beats;
    @(posedge clock);
    cpl_src_valid <= 1'b1;
    cpl_src <= b;
    @(posedge clock);
    while (cpl_src_ready !== 1'b1) @(posedge clock);
    cpl_src_valid <= 1'b0;
    while (beats == n) @(posedge clock);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    reg_rd(8'h00, d);
    check(d, 32'h0);
    reg_rd(8'h08, d);
    check(d, 32'h0);
    reg_rd(8'h20, d);
    check(d, 32'h0);
    reg_wr(8'h54, 32'hA5);
    reg_rd(8'h54, d);
    check(d, 32'hA5);
  endtask
  task automatic t_hints();
    rq_sideband_pkg::rq_fields_s f;
    f = '0;
    f.present = 2'h3;
    f.hint_type = 4'h9;
    f.lookup_sel = 2'h2;
    f.tag = 16'h357C;
    f.seq_first = 6'h15;
    f.seq_second = 6'h2A;
    send_rq(1'b1, 2'h3, f, '0);
    @(posedge clock);
    #1 check(hint_first, {1'b1, 2'h1, 8'h7C});
    check(hint_second, {1'b1, 2'h2, 8'hA5});
    repeat (2) @(posedge clock);
    #1 check({progress_valid_a, progress_sequence_out_a}, {1'b1, 6'h15});
    check({progress_valid_b, progress_sequence_out_b}, {1'b1, 6'h2A});
    f.present = 2'h0;
    send_rq(1'b0, 2'h1, f, '0);
    f.present = 2'h3;
    f.lookup_sel = 2'h0;
    send_rq(1'b1, 2'h0, f, '0);
    @(posedge clock);
    #1 check(hint_first, '0);
  endtask
  task automatic t_parity();
    rq_sideband_pkg::rq_fields_s f;
    logic [31:0] d;
    logic [511:0] p;
    f = '0;
    p = {16{32'h0123_4567}};
    reg_wr(8'h00, 32'h1);
    f.parity = odd_par(p);
    send_rq(1'b1, 2'h1, f, p);
    #1 check(request_nullify, 1'b0);
    f.parity = ~odd_par(p);
    send_rq(1'b0, 2'h1, f, p);
    f.parity = odd_par(p);
    send_rq(1'b1, 2'h0, f, p);
    #1 check({request_nullify, internal_error}, 2'h3);
    repeat (2) @(posedge clock);
    #1 check(irq, 1'b0);
    reg_wr(8'h08, 32'h1);
    repeat (2) @(posedge clock);
    #1 check(irq, 1'b1);
    reg_rd(8'h04, d);
    check(d[0], 1'b1);
    repeat (2) @(posedge clock);
    #1 check(irq, 1'b0);
    reg_wr(8'h00, 32'h0);
  endtask
  task automatic t_cpl();
    rq_sideband_pkg::cpl_src_s b;
    logic [3:0] therm [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
    b = '0;
    b.data = {16{32'hA5C3_0F1E}};
    stall <= 1'b1;
    b.first_beat = 1'b1;
    b.desc_dw = 5'h3;
    send_cpl(b);
    check({got_last, got_keep, got_side.packet_start_flags}, {1'b0, 16'hFFFF, 4'h1});
    check(got_side.byte_en, 64'hFFFF_FFFF_FFFF_F000);
    check(got_side.parity, odd_par(b.data));
    check(got_data, b.data);
    b.first_beat = 1'b0;
    b.last = 1'b1;
    b.desc_dw = 5'h0;
    b.end_dw = 4'h5;
    send_cpl(b);
    check({got_last, got_keep, got_side.packet_start_flags}, {1'b1, 16'h003F, 4'h0});
    check(got_side.byte_en, 64'h0000_0000_00FF_FFFF);
    reg_wr(8'h00, 32'h2);
    b.start_ptrs = 8'hE4;
    for (int k = 0; k < 5; k++) begin
      b.start_count = 3'(k);
      b.last = (k == 4);
      send_cpl(b);
      check(got_side.packet_start_flags, therm[k]);
      check({got_last, got_keep, got_side.start_ptrs}, {1'b0, 16'hFFFF, 8'hE4});
      check(got_side.is_eop, {3'h0, b.last});
    end
    stall <= 1'b0;
  endtask

  initial begin
    {reg_addr, reg_wdata, reg_write, reg_read, request_stream_valid, request_stream_end} = '0;
    {request_stream_payload, request_stream_starts, request_sideband} = '0;
    {cpl_src_valid, cpl_src, stall} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_hints();
    t_parity();
    t_cpl();
    conclude();
  end
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
endmodule
